// *** inc/msem_pkg.sv ***
// Package for the muting sequence error monitor: codes, states and timing constants
package msem_pkg;

  // ****************************************************************
  // Error codes (decimal number shown after the letter M)
  // ****************************************************************
  localparam logic [7:0] MSEM_CODE_NONE = 8'h00;
  localparam logic [7:0] MSEM_CODE_M53  = 8'h35;
  localparam logic [7:0] MSEM_CODE_M54  = 8'h36;
  localparam logic [7:0] MSEM_CODE_M55  = 8'h37;
  localparam logic [7:0] MSEM_CODE_M56  = 8'h38;
  localparam logic [7:0] MSEM_CODE_M57  = 8'h39;
  localparam logic [7:0] MSEM_CODE_M58  = 8'h3A;
  localparam logic [7:0] MSEM_CODE_M59  = 8'h3B;
  localparam logic [7:0] MSEM_CODE_M60  = 8'h3C;
  localparam logic [7:0] MSEM_CODE_M61  = 8'h3D;
  localparam logic [7:0] MSEM_CODE_M62  = 8'h3E;
  localparam logic [7:0] MSEM_CODE_M63  = 8'h3F;
  localparam logic [7:0] MSEM_CODE_M64  = 8'h40;
  localparam logic [7:0] MSEM_CODE_M65  = 8'h41;
  localparam logic [7:0] MSEM_CODE_M66  = 8'h42;
  localparam logic [7:0] MSEM_CODE_M67  = 8'h43;
  localparam logic [7:0] MSEM_CODE_M75  = 8'h4B;
  localparam logic [7:0] MSEM_CODE_M76  = 8'h4C;
  localparam logic [7:0] MSEM_CODE_M77  = 8'h4D;
  localparam logic [7:0] MSEM_CODE_M80  = 8'h50;
  localparam logic [7:0] MSEM_CODE_M81  = 8'h51;
  localparam logic [7:0] MSEM_CODE_M90  = 8'h5A;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam longint MSEM_CLK_HZ          = 125000000;
  localparam longint MSEM_PERMIT_MAX_S    = 300;
  localparam longint MSEM_BELT_MAX_H      = 8;
  localparam longint MSEM_PERMIT_CYCLES   = MSEM_PERMIT_MAX_S * MSEM_CLK_HZ;
  localparam longint MSEM_BELT_CYCLES     = MSEM_BELT_MAX_H * 3600 * MSEM_CLK_HZ;
  localparam longint MSEM_INIT_CYCLES     = 4 * MSEM_CLK_HZ;
  localparam longint MSEM_PAIR2_CYCLES    = 4 * MSEM_CLK_HZ;
  localparam longint MSEM_MUTE_CYCLES     = 600 * MSEM_CLK_HZ;
  localparam longint MSEM_OVERRIDE_CYCLES = 60 * MSEM_CLK_HZ;
  localparam int     MSEM_TMR_W           = 48;

  typedef enum logic [2:0] {
    MSEM_IDLE,
    MSEM_START,
    MSEM_ACTIVE,
    MSEM_ENDING
  } msem_state_e;

endpackage : msem_pkg

// *** core/msem_monitor.sv ***
// Muting sequence error monitor: sequence, timing and field checks with first-error latch
`timescale 1ns/1ps
`default_nettype none

// Function
// - Error code held until next muting cycle
// - First error latched, later ones ignored
// - M53 when start time expires
// - M54 when second pair too slow
// - M55 first signal withdrawn without follow-up
// - M56 wrong linear start sequence
// - M57-M59 swapped activation order
// - M60/M61 wrong release order: M61 second release, M60 first or third
// - M62 sensor rises while ending muting
// - M63 permit held 300 s or longer
// - M64 permit dropped before muting valid
// - M66 field occupied at muting end
// - M67 field penetrated before muting active
// - M75 field change during belt stop
// - M76 sensor change during belt stop
// - M77 belt stop held 8 h
// - M80 unmuted beam cut in partial muting
// - M81 slave off cancels muting, outputs off
// - M90 override overtime, shown while held
module msem_monitor
  import msem_pkg::*;
#(
  parameter longint PERMIT_CYCLES   = MSEM_PERMIT_CYCLES,
  parameter longint BELT_CYCLES     = MSEM_BELT_CYCLES,
  parameter longint INIT_CYCLES     = MSEM_INIT_CYCLES,
  parameter longint PAIR2_CYCLES    = MSEM_PAIR2_CYCLES,
  parameter longint MUTE_CYCLES     = MSEM_MUTE_CYCLES,
  parameter longint OVERRIDE_CYCLES = MSEM_OVERRIDE_CYCLES
) (
  // Clock and reset
  input  wire logic       I_CLK,
  input  wire logic       I_RESET_N,
  // Muting sensors, index 0 is the first signal of the sequence
  input  wire logic [3:0] I_BYPASS_SENSOR,
  // Configuration
  input  wire logic       I_FOUR_SENSORS,
  input  wire logic       I_TWO_PAIRS,
  input  wire logic       I_LINEAR_SEQ,
  input  wire logic       I_PARTIAL,
  // Control inputs
  input  wire logic       I_PERMIT,
  input  wire logic       I_PERMIT_USED,
  input  wire logic       I_BELT_STOP,
  input  wire logic       I_OVERRIDE,
  input  wire logic       I_SLAVE_OFF,
  // Safety field
  input  wire logic       I_FIELD_BROKEN,
  input  wire logic       I_UNMUTED_BROKEN,
  // Outputs
  output logic [7:0]      O_ERROR_CODE,
  output logic            O_ERROR_VALID,
  output logic            O_MUTING_ACTIVE,
  output logic            O_SAFETY_SWITCH_OUTPUT
);

  initial begin
    if (PERMIT_CYCLES < 1 || BELT_CYCLES < 1 || INIT_CYCLES < 1 || PAIR2_CYCLES < 1 ||
        MUTE_CYCLES < 1 || OVERRIDE_CYCLES < 1) begin
      $error("msem_monitor: timing counts must be at least one cycle");
    end
  end

  // ****************************************************************
  // State
  // ****************************************************************
  msem_state_e            state_reg, state_next;
  logic [3:0]             sens_reg, sens_next;
  logic [3:0]             seen_reg, seen_next;
  logic                   field_reg, field_next;
  logic                   belt_reg, belt_next;
  logic [MSEM_TMR_W-1:0]  phase_tmr_reg, phase_tmr_next;
  logic [MSEM_TMR_W-1:0]  permit_tmr_reg, permit_tmr_next;
  logic [MSEM_TMR_W-1:0]  belt_tmr_reg, belt_tmr_next;
  logic [MSEM_TMR_W-1:0]  ovr_tmr_reg, ovr_tmr_next;
  logic [7:0]             code_reg, code_next;
  logic                   valid_reg, valid_next;
  logic                   ovr_err_reg, ovr_err_next;
  logic                   ssw_reg, ssw_next;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  logic [3:0]  used;
  logic [3:0]  rise;
  logic [3:0]  fall;
  logic [3:0]  early;
  logic [2:0]  need;
  logic [7:0]  err;
  logic        err_hit;
  logic        abort;
  logic        cycle_start;

  always_comb begin
    used        = I_FOUR_SENSORS ? 4'hF : 4'h3;
    need        = I_FOUR_SENSORS ? 3'd4 : 3'd2;
    rise        = I_BYPASS_SENSOR & ~sens_reg & used;
    fall        = ~I_BYPASS_SENSOR & sens_reg & used;
    early       = rise & ~(seen_reg << 1) & ~seen_reg;
    state_next  = state_reg;
    seen_next   = seen_reg;
    sens_next   = I_BYPASS_SENSOR & used;
    field_next  = I_FIELD_BROKEN;
    belt_next   = I_BELT_STOP;
    err         = MSEM_CODE_NONE;
    err_hit     = 1'b0;
    abort       = 1'b0;
    cycle_start = 1'b0;
    phase_tmr_next  = (state_reg == MSEM_IDLE) ? '0 : phase_tmr_reg + 1'b1;
    permit_tmr_next = I_PERMIT ? permit_tmr_reg + 1'b1 : '0;
    belt_tmr_next   = I_BELT_STOP ? belt_tmr_reg + 1'b1 : '0;
    ovr_tmr_next    = I_OVERRIDE ? ovr_tmr_reg + 1'b1 : '0;

    case (state_reg)
      MSEM_IDLE: begin
        if (rise[0]) begin
          state_next  = MSEM_START;
          // A second signal rising in the same cycle counts as already seen
          seen_next   = rise;
          cycle_start = 1'b1;
        end else if (rise[1] && !I_LINEAR_SEQ) begin
          err = MSEM_CODE_M57; err_hit = 1'b1; cycle_start = 1'b1;
        end else if (|rise && I_LINEAR_SEQ) begin
          err = MSEM_CODE_M56; err_hit = 1'b1; cycle_start = 1'b1;
        end
      end
      MSEM_START: begin
        if (I_FIELD_BROKEN) begin
          err = MSEM_CODE_M67; err_hit = 1'b1;
        end else if (seen_reg == 4'h1 && fall[0] && !(|rise[3:1])) begin
          err = MSEM_CODE_M55; err_hit = 1'b1;
        end else if (|early) begin
          // A signal arrived ahead of its predecessor; the early signal names the swapped pair
          if (I_LINEAR_SEQ) begin
            err = MSEM_CODE_M56;
          end else if (early[1]) begin
            err = MSEM_CODE_M57;
          end else if (early[2]) begin
            err = MSEM_CODE_M58;
          end else begin
            err = MSEM_CODE_M59;
          end
          err_hit = 1'b1;
        end else if (I_PERMIT_USED && sens_reg != 4'h0 && !I_PERMIT) begin
          err = MSEM_CODE_M64; err_hit = 1'b1;
        end else if (I_TWO_PAIRS && seen_reg[1] && !seen_reg[2] && phase_tmr_reg >= PAIR2_CYCLES) begin
          err = MSEM_CODE_M54; err_hit = 1'b1;
        end else if (phase_tmr_reg >= INIT_CYCLES) begin
          err = MSEM_CODE_M53; err_hit = 1'b1;
        end else begin
          seen_next = seen_reg | rise;
          if (((seen_reg | rise) & used) == used && (!I_PERMIT_USED || I_PERMIT)) begin
            state_next     = MSEM_ACTIVE;
            seen_next      = 4'h0;
            phase_tmr_next = '0;
          end
        end
      end
      MSEM_ACTIVE: begin
        if (I_PARTIAL && I_UNMUTED_BROKEN) begin
          err = MSEM_CODE_M80; err_hit = 1'b1;
        end else if (phase_tmr_reg >= MUTE_CYCLES) begin
          err = MSEM_CODE_M65; err_hit = 1'b1;
        end else if (|fall) begin
          // Releases must follow the activation order, first signal first
          if (fall != 4'h1 && !fall[0]) begin
            err = MSEM_CODE_M60; err_hit = 1'b1;
          end else begin
            state_next = MSEM_ENDING;
            seen_next  = fall;
          end
        end
      end
      MSEM_ENDING: begin
        if (|rise) begin
          err = MSEM_CODE_M62; err_hit = 1'b1;
        end else if (|(fall & ~(seen_reg << 1) & ~seen_reg)) begin
          err = seen_reg == 4'h1 ? MSEM_CODE_M61 : MSEM_CODE_M60;
          err_hit = 1'b1;
        end else begin
          seen_next = seen_reg | fall;
          if ((sens_reg & ~fall) == 4'h0 && need != 3'd0) begin
            if (I_FIELD_BROKEN) begin
              err = MSEM_CODE_M66; err_hit = 1'b1;
            end else begin
              state_next = MSEM_IDLE;
            end
          end
        end
      end
      default: begin
        state_next = MSEM_IDLE;
      end
    endcase

    // Checks that apply regardless of the sequence phase
    if (I_SLAVE_OFF) begin
      err = MSEM_CODE_M81; err_hit = 1'b1;
    end else if (belt_reg && I_FIELD_BROKEN != field_reg) begin
      err = MSEM_CODE_M75; err_hit = 1'b1;
    end else if (belt_reg && (I_BYPASS_SENSOR & used) != sens_reg) begin
      err = MSEM_CODE_M76; err_hit = 1'b1;
    end else if (belt_tmr_reg >= BELT_CYCLES) begin
      err = MSEM_CODE_M77; err_hit = 1'b1;
    end else if (permit_tmr_reg >= PERMIT_CYCLES) begin
      err = MSEM_CODE_M63; err_hit = 1'b1;
    end
    if (belt_reg && !err_hit) begin
      state_next     = state_reg;
      phase_tmr_next = phase_tmr_reg;
    end
    if (err_hit) begin
      abort = 1'b1;
      state_next     = MSEM_IDLE;
      seen_next      = 4'h0;
      phase_tmr_next = '0;
    end

    // Code latch: a new cycle clears, the first error sticks
    code_next  = code_reg;
    valid_next = valid_reg;
    if (cycle_start && !err_hit) begin
      code_next  = MSEM_CODE_NONE;
      valid_next = 1'b0;
    end
    if (err_hit && (!valid_reg || cycle_start)) begin
      code_next  = err;
      valid_next = 1'b1;
    end

    // Override error shown only while the request is held
    ovr_err_next = I_OVERRIDE && (ovr_tmr_reg >= OVERRIDE_CYCLES);
    if (ovr_tmr_reg == {MSEM_TMR_W{1'b1}}) begin
      ovr_tmr_next = ovr_tmr_reg;
    end
    if (belt_tmr_reg == {MSEM_TMR_W{1'b1}}) begin
      belt_tmr_next = belt_tmr_reg;
    end
    if (permit_tmr_reg == {MSEM_TMR_W{1'b1}}) begin
      permit_tmr_next = permit_tmr_reg;
    end

    ssw_next = !I_SLAVE_OFF && !abort && (!I_FIELD_BROKEN || state_next == MSEM_ACTIVE);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state_reg      <= MSEM_IDLE;
      sens_reg       <= 4'h0;
      seen_reg       <= 4'h0;
      field_reg      <= 1'b0;
      belt_reg       <= 1'b0;
      phase_tmr_reg  <= '0;
      permit_tmr_reg <= '0;
      belt_tmr_reg   <= '0;
      ovr_tmr_reg    <= '0;
      code_reg       <= MSEM_CODE_NONE;
      valid_reg      <= 1'b0;
      ovr_err_reg    <= 1'b0;
      ssw_reg        <= 1'b0;
    end else begin
      state_reg      <= state_next;
      sens_reg       <= sens_next;
      seen_reg       <= seen_next;
      field_reg      <= field_next;
      belt_reg       <= belt_next;
      phase_tmr_reg  <= phase_tmr_next;
      permit_tmr_reg <= permit_tmr_next;
      belt_tmr_reg   <= belt_tmr_next;
      ovr_tmr_reg    <= ovr_tmr_next;
      code_reg       <= code_next;
      valid_reg      <= valid_next;
      ovr_err_reg    <= ovr_err_next;
      ssw_reg        <= ssw_next;
    end
  end

  // Override overtime takes the display while held, without disturbing the latch
  assign O_ERROR_CODE           = ovr_err_reg ? MSEM_CODE_M90 : code_reg;
  assign O_ERROR_VALID          = ovr_err_reg | valid_reg;
  assign O_MUTING_ACTIVE        = (state_reg == MSEM_ACTIVE);
  assign O_SAFETY_SWITCH_OUTPUT = ssw_reg;

endmodule : msem_monitor

`default_nettype wire

// *** tb/msem_sva.sv ***
// Port checker for the muting sequence error monitor
`timescale 1ns/1ps
`default_nettype none
module msem_sva
  import msem_pkg::*;
#(
  parameter longint OVERRIDE_CYCLES = 20
) (
  // Clock and reset
  input wire logic       I_CLK,
  input wire logic       I_RESET_N,
  // Inputs
  input wire logic [3:0] I_BYPASS_SENSOR,
  input wire logic       I_FOUR_SENSORS,
  input wire logic       I_BELT_STOP,
  input wire logic       I_OVERRIDE,
  input wire logic       I_SLAVE_OFF,
  input wire logic       I_FIELD_BROKEN,
  // Outputs
  input wire logic [7:0] O_ERROR_CODE,
  input wire logic       O_ERROR_VALID,
  input wire logic       O_MUTING_ACTIVE,
  input wire logic       O_SAFETY_SWITCH_OUTPUT
);
  // ****
  // Override hold counter
  // ****
  logic [15:0] ovr_cnt_reg;
  logic [15:0] ovr_cnt_next;
  always_comb begin
    ovr_cnt_next = I_OVERRIDE ? ovr_cnt_reg + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) ovr_cnt_reg <= 16'h0000;
    else ovr_cnt_reg <= ovr_cnt_next;
  end
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RESET_N);
  // Override code is left out: it follows the key, not the cycle
  AST_CODE_HOLD: assert property (O_ERROR_VALID && !I_BYPASS_SENSOR[0] && !I_OVERRIDE
    && O_ERROR_CODE != MSEM_CODE_M90 |=> O_ERROR_VALID && $stable(O_ERROR_CODE)) else $error("code changed");
  AST_VALID_CODE: assert property (O_ERROR_VALID |-> O_ERROR_CODE != MSEM_CODE_NONE)
    else $error("valid without code");
  AST_SLAVE_OFF: assert property (I_SLAVE_OFF |=> !O_SAFETY_SWITCH_OUTPUT && !O_MUTING_ACTIVE)
    else $error("outputs on with slave off");
  AST_M81: assert property ($rose(I_SLAVE_OFF) && !O_ERROR_VALID |=> O_ERROR_CODE == MSEM_CODE_M81)
    else $error("slave code missing");
  AST_M90_EARLY: assert property (ovr_cnt_reg + 2 < OVERRIDE_CYCLES |-> O_ERROR_CODE != MSEM_CODE_M90)
    else $error("override code early");
  AST_M90_LATE: assert property (ovr_cnt_reg == OVERRIDE_CYCLES + 4 |-> O_ERROR_VALID)
    else $error("override code late");
  AST_M67: assert property (I_BYPASS_SENSOR == 4'h1 && $stable(I_BYPASS_SENSOR) && $rose(I_FIELD_BROKEN)
    && !O_ERROR_VALID && !O_MUTING_ACTIVE && !I_BELT_STOP && !I_SLAVE_OFF && !I_OVERRIDE
    |=> O_ERROR_CODE == MSEM_CODE_M67) else $error("early field code missing");
  AST_M75: assert property (I_BELT_STOP && $past(I_BELT_STOP) && $changed(I_FIELD_BROKEN)
    && !O_ERROR_VALID && !I_SLAVE_OFF |=> O_ERROR_CODE == MSEM_CODE_M75) else $error("belt field code missing");
  AST_M76: assert property (I_BELT_STOP && $past(I_BELT_STOP)
    && !$stable(I_BYPASS_SENSOR & (I_FOUR_SENSORS ? 4'hF : 4'h3))
    && $stable(I_FIELD_BROKEN) && !O_ERROR_VALID && !I_SLAVE_OFF |=> O_ERROR_CODE == MSEM_CODE_M76)
    else $error("belt sensor code missing");
  cover property (O_MUTING_ACTIVE);
  cover property (O_ERROR_CODE == MSEM_CODE_M90);
  cover property ($rose(I_SLAVE_OFF));
endmodule : msem_sva
bind msem_monitor msem_sva #(.OVERRIDE_CYCLES(OVERRIDE_CYCLES)) u_sva (.*);
`default_nettype wire

// *** tb/msem_partner.sv ***
// Model of the muting sensors, permit, belt-stop and override sources
`timescale 1ns/1ps
`default_nettype none
module msem_partner (
  // Clock and bench commands
  input  wire logic       i_clk,
  input  wire logic [3:0] i_sensor_cmd,
  input  wire logic [2:0] i_ctl_cmd,
  input  wire logic       i_muting_active,
  // Lines into the monitor
  output logic [3:0]      o_bypass_sensor,
  output logic            o_permit,
  output logic            o_belt_stop,
  output logic            o_override
);
  logic done_reg = 1'b0;
  // Permit is withdrawn once muting runs; a cycle that never mutes holds it only while sensor 0 does
  always @(posedge i_clk) done_reg <= (done_reg | i_muting_active) & (|i_sensor_cmd);
  assign o_permit        = i_sensor_cmd[0] & ~i_ctl_cmd[2] & ~done_reg;
  assign o_bypass_sensor = i_sensor_cmd;
  assign o_belt_stop     = i_ctl_cmd[0];
  assign o_override      = i_ctl_cmd[1];
endmodule : msem_partner
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the muting sequence error monitor
`timescale 1ns/1ps
`default_nettype none
module tb;
  import msem_pkg::*;
  localparam longint PERMIT_N = 40;
  localparam longint BELT_N   = 50;
  localparam longint INIT_N   = 50;
  localparam longint PAIR2_N  = 20;
  localparam longint MUTE_N   = 30;
  localparam longint OVR_N    = 20;
  logic        I_CLK     = 1'b0;
  logic        I_RESET_N = 1'b0;
  logic [3:0]  sens_cmd  = 4'h0;
  logic [5:0]  ctl       = 6'h00;
  logic [4:0]  cfg       = 5'h00;
  logic [3:0]  sensor;
  logic        permit, belt, ovr, valid, active, safe;
  logic        valid_d   = 1'b0;
  logic [7:0]  code;
  logic [7:0]  exp_v;
  logic [31:0] lfsr_reg  = 32'hDC6382B7;
  logic [7:0]  exp_q[$];
  int          miscompares = 0;
  int          checked     = 0;
  // ****
  // Scenarios: config, two codes, six steps of sensors, controls and wait, oldest step highest
  // ****
  logic [140:0] sc [23] = '{
    {5'h10, 16'h0000, 120'h10002300022000200004}, {5'h00, 16'h3700, 120'h1000200004},
    {5'h01, 16'h3900, 120'h2000230004}, {5'h01, 16'h3A00, 120'h100025000270004},
    {5'h01, 16'h3B00, 120'h30002B0002F0004}, {5'h04, 16'h3800, 120'h2000230004},
    {5'h00, 16'h3500, 120'h10436}, {5'h03, 16'h3600, 120'h1000230018},
    {5'h00, 16'h3C00, 120'h100023000210004}, {5'h01, 16'h3D00, 120'h100023000270002F0002E0002A0004},
    {5'h00, 16'h3E00, 120'h10002300022000230004}, {5'h00, 16'h4200, 120'h1000230002308022080200804},
    {5'h00, 16'h4300, 120'h1000210804}, {5'h10, 16'h4000, 120'h1000210404},
    {5'h10, 16'h3F00, 120'h1002C}, {5'h00, 16'h4100, 120'h1000230022},
    {5'h00, 16'h4B00, 120'h10002300023010230904}, {5'h00, 16'h4C00, 120'h10002300023010210104},
    {5'h00, 16'h4D00, 120'h00136}, {5'h08, 16'h5000, 120'h100023000231004},
    {5'h00, 16'h5100, 120'h100023000232004}, {5'h00, 16'h5A00, 120'h0021C00004},
    {5'h00, 16'h4337, 120'h100021080202002000021000200004}};
  msem_partner u_partner (.i_clk(I_CLK), .i_sensor_cmd(sens_cmd), .i_ctl_cmd(ctl[2:0]), .i_muting_active(active),
    .o_bypass_sensor(sensor), .o_permit(permit), .o_belt_stop(belt), .o_override(ovr));
  msem_monitor #(.PERMIT_CYCLES(PERMIT_N), .BELT_CYCLES(BELT_N), .INIT_CYCLES(INIT_N), .PAIR2_CYCLES(PAIR2_N),
    .MUTE_CYCLES(MUTE_N), .OVERRIDE_CYCLES(OVR_N)) u_dut (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N),
    .I_BYPASS_SENSOR(sensor), .I_FOUR_SENSORS(cfg[0]), .I_TWO_PAIRS(cfg[1]), .I_LINEAR_SEQ(cfg[2]),
    .I_PARTIAL(cfg[3]), .I_PERMIT(permit), .I_PERMIT_USED(cfg[4]), .I_BELT_STOP(belt), .I_OVERRIDE(ovr),
    .I_SLAVE_OFF(ctl[5]), .I_FIELD_BROKEN(ctl[3]), .I_UNMUTED_BROKEN(ctl[4]), .O_ERROR_CODE(code),
    .O_ERROR_VALID(valid), .O_MUTING_ACTIVE(active), .O_SAFETY_SWITCH_OUTPUT(safe));
  always #4 I_CLK = ~I_CLK;
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic rst(input logic [4:0] c);
    @(negedge I_CLK);
    I_RESET_N = 1'b0;
    cfg = c;
    sens_cmd = 4'h0;
    ctl = 6'h00;
    repeat (4) @(negedge I_CLK);
    I_RESET_N = 1'b1;
  endtask : rst
  // Random stretch only lengthens a step, so every timeout wait still runs past its short time limit
  task automatic step(input logic [19:0] w);
    @(negedge I_CLK);
    sens_cmd = w[19:16];
    ctl = w[13:8];
    lfsr_reg = lfsr(lfsr_reg);
    repeat (w[7:0] + lfsr_reg[1:0]) @(negedge I_CLK);
  endtask : step
  // A code is judged when it first appears
  always @(negedge I_CLK) begin
    if (valid === 1'b1 && valid_d !== 1'b1) begin
      exp_v = exp_q.size() > 0 ? exp_q.pop_front() : MSEM_CODE_NONE;
      chk("code", code, exp_v);
      // Every error but the override one aborts: outputs off, muting dropped
      chk("switch", {7'h00, safe}, {7'h00, exp_v == MSEM_CODE_M90});
      chk("muting", {7'h00, active}, 8'h00);
    end
    valid_d <= valid;
  end
  initial begin
    foreach (sc[i]) begin
      rst(sc[i][140:136]);
      if (sc[i][135:128] != 8'h00) exp_q.push_back(sc[i][135:128]);
      if (sc[i][127:120] != 8'h00) exp_q.push_back(sc[i][127:120]);
      for (int j = 5; j >= 0; j--) begin
        if (sc[i][j*20 +: 20] != 20'h00000) step(sc[i][j*20 +: 20]);
      end
      repeat (4) @(negedge I_CLK);
      chk("codes still pending", 8'(exp_q.size()), 8'h00);
    end
    give_verdict();
  end
  initial begin
    #(8 * 6000);
    miscompares++;
    give_verdict();
  end
endmodule : tb
`default_nettype wire
